// >>> inc/iedd_map.vh
// Register map, field positions, reset values and timing counts for the input event block
`ifndef IEDD_MAP_VH
`define IEDD_MAP_VH
// Register byte offsets
`define IEDD_CTRL       8'h00
`define IEDD_CMD        8'h04
`define IEDD_FLAGS      8'h08
`define IEDD_ACT_DELAY  8'h0c
`define IEDD_HOLD_DUR   8'h10
`define IEDD_RATE_LIM   8'h14
`define IEDD_PROC_MODE  8'h18
`define IEDD_UPPER_CUT  8'h1c
`define IEDD_LOWER_CUT  8'h20
`define IEDD_FRONT_GAIN 8'h24
`define IEDD_SMOOTH     8'h28
`define IEDD_IRQ_STAT   8'h2c
`define IEDD_IRQ_MASK   8'h30
// Control bits
`define IEDD_CTRL_SILENCE 0
`define IEDD_CTRL_DUR_EN  1
`define IEDD_CTRL_RATE_EN 2
`define IEDD_CTRL_LIMITED 3
// Command bits (write one to act)
`define IEDD_CMD_HIGH    0
`define IEDD_CMD_LOW     1
`define IEDD_CMD_BLIP    2
`define IEDD_CMD_RELEASE 3
// Flag word bits
`define IEDD_F_TRUE 0
`define IEDD_F_RISE 1
`define IEDD_F_FALL 2
`define IEDD_F_ACT  3
`define IEDD_F_PASS 4
`define IEDD_F_FAIL 5
// Processing modes
`define IEDD_MODE_OFF     2'h0
`define IEDD_MODE_SIMPLE  2'h1
`define IEDD_MODE_COMPLEX 2'h2
// Reset values: times in milliseconds, rate in hertz
`define IEDD_ACT_MS_RST  32'h0000_0064
`define IEDD_HOLD_MS_RST 32'h0000_01f4
`define IEDD_RATE_RST    32'h0000_000a
// Timing: clock is 10 MHz, 100 ns per cycle
`define IEDD_CLK_HZ      32'd10000000
`define IEDD_MS_CYCLES   (`IEDD_CLK_HZ / 32'd1000)
// Last count of the millisecond divider, cycles per millisecond less one
`define IEDD_MS_LAST     16'h270f
`endif

// >>> hdl/iedd_ms_tick.v
// Millisecond tick divider for the input event block
`timescale 1ns/10ps
`include "iedd_map.vh"
module iedd_ms_tick (
   // Clock and reset
   input  wire aclk,
   input  wire aresetn,
   input  wire ce,
   // Tick out
   output reg  tick_q
);
   reg [15:0] cnt_q;

   // Divide the clock to one pulse per millisecond
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q  <= 16'h0000;
         tick_q <= 1'b0;
      end else if (ce) begin
         if (cnt_q == `IEDD_MS_LAST) begin
            cnt_q  <= 16'h0000;
            tick_q <= 1'b1;
         end else begin
            cnt_q  <= cnt_q + 16'h0001;
            tick_q <= 1'b0;
         end
      end
   end
endmodule // iedd_ms_tick

// >>> hdl/iedd_top.v
// Input event and duration detector with AXI4-Lite registers
// Summary of operation
// - Flag a rise event when the logic level goes false to true.
// - Flag a fall event when the logic level goes true to false.
// - With duration testing on, flag active once the activation time is met.
// - With duration testing on, flag pass once the hold time is met.
// - Flag fail only after activation passed and the hold time then fails.
// - Present six flags as one word: fail, pass, active, fall, rise, true.
// - A silenced input triggers no events.
// - Force-high command drives the level true.
// - Force-low command drives the level false.
// - Blip command drives the level true briefly then false.
// - Activation time override honoured only with duration testing enabled.
// - Hold time override honoured only with duration testing enabled.
// - Rate limit override honoured only with rate testing enabled.
// - High and low queries report the present logic level.
// - Cutoff overrides accepted only in complex mode with limited range.
// - Gain override accepted only in simple or complex mode.
// - Smoothing constant accepted only in complex mode; zero disables it.
`timescale 1ns/10ps
`include "iedd_map.vh"
module iedd_top (
   // Clock, reset, enable
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        ce,
   // Input pin
   input  wire        raw_in,
   // AXI4-Lite write address and data
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Event pulses and status
   output reg         on_rising_edge,
   output reg         on_falling_edge,
   output reg         on_activation_reached,
   output reg         on_hold_passed,
   output reg         on_hold_failed,
   output reg         query_high,
   output reg         query_low,
   output wire        irq
);
   // Duration states
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_WAIT = 3'b010;
   localparam [2:0] ST_HOLD = 3'b100;

   reg        sync1_q, sync2_q;
   reg        level_q, prev_q;
   reg [1:0]  force_q;             // 00 pin, 01 high, 10 low
   reg        blip_q;
   reg [3:0]  ctrl_q;
   reg [31:0] act_ms_q, hold_ms_q, rate_q;
   reg [1:0]  mode_q;
   reg [31:0] upper_q, lower_q, gain_q, smooth_q;
   reg [5:0]  stat_q, mask_q;
   reg [5:0]  flags_q;
   reg [2:0]  st_q;
   reg [31:0] ms_cnt_q;
   reg        aw_q, w_q;
   reg [7:0]  awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0]  wstrb_q;
   wire       ms_tick;

   // Free-running tick; the first millisecond after a rise may be short
   iedd_ms_tick u_tick (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .tick_q  (ms_tick)
   );

   // Byte-lane merge for register writes
   function [31:0] merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  be;
      integer i;
      begin
         merge = old_v;
         for (i = 0; i < 4; i = i + 1) begin
            if (be[i]) begin
               merge[i*8 +: 8] = new_v[i*8 +: 8];
            end
         end
      end
   endfunction

   // Address is a known register
   function mapped;
      input [7:0] a;
      begin
         mapped = (a[1:0] == 2'b00) && (a <= `IEDD_IRQ_MASK);
      end
   endfunction

   // Write channel handshakes; both captured before a response issues
   // Readies drop while frozen, else a beat would be taken and then lost
   assign s_axi_awready = ce && !aw_q && !s_axi_bvalid;
   assign s_axi_wready  = ce && !w_q && !s_axi_bvalid;
   assign s_axi_arready = ce && !s_axi_rvalid;
   wire do_wr = aw_q && w_q && !s_axi_bvalid;
   wire cmd_wr = do_wr && (awaddr_q == `IEDD_CMD);
   wire dur_en = ctrl_q[`IEDD_CTRL_DUR_EN];
   wire silent = ctrl_q[`IEDD_CTRL_SILENCE];

   // Effective level: pin, forced high/low, or one-cycle blip
   wire level_d = blip_q ? 1'b1 :
                  (force_q == 2'b01) ? 1'b1 :
                  (force_q == 2'b10) ? 1'b0 : sync2_q;

   // Event conditions; silencing blocks every event
   wire ev_rise = !silent && level_q && !prev_q;
   wire ev_fall = !silent && !level_q && prev_q;
   wire ev_act  = !silent && dur_en && (st_q == ST_WAIT) && level_q
                  && ms_tick && (ms_cnt_q + 32'd1 >= act_ms_q);
   wire ev_pass = !silent && dur_en && (st_q == ST_HOLD) && level_q
                  && ms_tick && (ms_cnt_q + 32'd1 >= hold_ms_q);
   // A fall while waiting gives no fail event; only a fall during the hold fails
   wire ev_fail = !silent && dur_en && (st_q == ST_HOLD) && !level_q;
   wire [5:0] ev = {ev_fail, ev_pass, ev_act, ev_fall, ev_rise, 1'b0};

   // Pin synchroniser, level tracking and force commands
   always @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         level_q <= 1'b0;
         prev_q  <= 1'b0;
         force_q <= 2'b00;
         blip_q  <= 1'b0;
      end else if (ce) begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
         level_q <= level_d;
         prev_q  <= level_q;
         blip_q  <= 1'b0;
         if (cmd_wr) begin
            if (wdata_q[`IEDD_CMD_HIGH]) begin
               force_q <= 2'b01;
            end else if (wdata_q[`IEDD_CMD_LOW]) begin
               force_q <= 2'b10;
            end else if (wdata_q[`IEDD_CMD_BLIP]) begin
               // Level stays forced low afterwards until a release or force-high command
               force_q <= 2'b10;
               blip_q  <= 1'b1;
            end else if (wdata_q[`IEDD_CMD_RELEASE]) begin
               force_q <= 2'b00;
            end
         end
      end
   end

   // Duration test: wait for activation time, then hold for pass time
   always @(posedge aclk) begin
      if (!aresetn) begin
         st_q     <= ST_IDLE;
         ms_cnt_q <= 32'h0000_0000;
      end else if (ce) begin
         case (st_q)
            ST_IDLE: begin
               ms_cnt_q <= 32'h0000_0000;
               if (dur_en && ev_rise) begin
                  st_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (!level_q || !dur_en) begin
                  st_q <= ST_IDLE;
               end else if (ev_act) begin
                  st_q     <= ST_HOLD;
                  ms_cnt_q <= 32'h0000_0000;
               end else if (ms_tick) begin
                  ms_cnt_q <= ms_cnt_q + 32'd1;
               end
            end
            ST_HOLD: begin
               if (!level_q || !dur_en || ev_pass) begin
                  st_q <= ST_IDLE;
               end else if (ms_tick) begin
                  ms_cnt_q <= ms_cnt_q + 32'd1;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // Event pulses, flag word and level queries come from flip-flops
   always @(posedge aclk) begin
      if (!aresetn) begin
         on_rising_edge        <= 1'b0;
         on_falling_edge       <= 1'b0;
         on_activation_reached <= 1'b0;
         on_hold_passed        <= 1'b0;
         on_hold_failed        <= 1'b0;
         flags_q               <= 6'h00;
         query_high            <= 1'b0;
         query_low             <= 1'b1;
      end else if (ce) begin
         on_rising_edge        <= ev_rise;
         on_falling_edge       <= ev_fall;
         on_activation_reached <= ev_act;
         on_hold_passed        <= ev_pass;
         on_hold_failed        <= ev_fail;
         flags_q               <= {ev[5:1], level_q};
         query_high            <= level_q;
         query_low             <= !level_q;
      end
   end

   // Register writes; overrides gated by mode and test enables
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q    <= 4'h0;
         act_ms_q  <= `IEDD_ACT_MS_RST;
         hold_ms_q <= `IEDD_HOLD_MS_RST;
         rate_q    <= `IEDD_RATE_RST;
         mode_q    <= `IEDD_MODE_OFF;
         upper_q   <= 32'h0000_0000;
         lower_q   <= 32'h0000_0000;
         gain_q    <= 32'h0000_0000;
         smooth_q  <= 32'h0000_0000;                               // Zero: smoothing off
         mask_q    <= 6'h00;
      end else if (ce && do_wr) begin
         case (awaddr_q)
            // Control, mode and mask take byte lane 0 only
            `IEDD_CTRL:      ctrl_q <= wstrb_q[0] ? wdata_q[3:0] : ctrl_q;
            `IEDD_ACT_DELAY: if (dur_en) act_ms_q <= merge(act_ms_q, wdata_q, wstrb_q);
            `IEDD_HOLD_DUR:  if (dur_en) hold_ms_q <= merge(hold_ms_q, wdata_q, wstrb_q);
            `IEDD_RATE_LIM:  if (ctrl_q[`IEDD_CTRL_RATE_EN])
                                rate_q <= merge(rate_q, wdata_q, wstrb_q);
            `IEDD_PROC_MODE: mode_q <= wstrb_q[0] ? wdata_q[1:0] : mode_q;
            `IEDD_UPPER_CUT: if (mode_q == `IEDD_MODE_COMPLEX && ctrl_q[`IEDD_CTRL_LIMITED])
                                upper_q <= merge(upper_q, wdata_q, wstrb_q);
            `IEDD_LOWER_CUT: if (mode_q == `IEDD_MODE_COMPLEX && ctrl_q[`IEDD_CTRL_LIMITED])
                                lower_q <= merge(lower_q, wdata_q, wstrb_q);
            `IEDD_FRONT_GAIN: if (mode_q == `IEDD_MODE_SIMPLE || mode_q == `IEDD_MODE_COMPLEX)
                                gain_q <= merge(gain_q, wdata_q, wstrb_q);
            `IEDD_SMOOTH:    if (mode_q == `IEDD_MODE_COMPLEX)
                                smooth_q <= merge(smooth_q, wdata_q, wstrb_q);
            `IEDD_IRQ_MASK:  mask_q <= wstrb_q[0] ? wdata_q[5:0] : mask_q;
            default: ;
         endcase
      end
   end

   // Sticky interrupt status; a new event beats a write-one clear
   // Bit 0 never sets: the true flag is a level, not an event
   always @(posedge aclk) begin
      if (!aresetn) begin
         stat_q <= 6'h00;
      end else if (ce) begin
         if (do_wr && awaddr_q == `IEDD_IRQ_STAT && wstrb_q[0]) begin
            stat_q <= (stat_q & ~wdata_q[5:0]) | ev;
         end else begin
            stat_q <= stat_q | ev;
         end
      end
   end
   // Level interrupt while any unmasked status bit stands
   assign irq = |(stat_q & mask_q);

   // AXI write channel capture and response
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_q         <= 1'b0;
         w_q          <= 1'b0;
         awaddr_q     <= 8'h00;
         wdata_q      <= 32'h0000_0000;
         wstrb_q      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q     <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q     <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awaddr_q) ? 2'b00 : 2'b10;      // SLVERR if unmapped
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI read: one cycle after the address is taken
   // The command register and unknown offsets read as zero
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
            case (s_axi_araddr)
               `IEDD_CTRL:       s_axi_rdata <= {28'h0, ctrl_q};
               `IEDD_FLAGS:      s_axi_rdata <= {26'h0, flags_q};
               `IEDD_ACT_DELAY:  s_axi_rdata <= act_ms_q;
               `IEDD_HOLD_DUR:   s_axi_rdata <= hold_ms_q;
               `IEDD_RATE_LIM:   s_axi_rdata <= rate_q;
               `IEDD_PROC_MODE:  s_axi_rdata <= {30'h0, mode_q};
               `IEDD_UPPER_CUT:  s_axi_rdata <= upper_q;
               `IEDD_LOWER_CUT:  s_axi_rdata <= lower_q;
               `IEDD_FRONT_GAIN: s_axi_rdata <= gain_q;
               `IEDD_SMOOTH:     s_axi_rdata <= smooth_q;
               `IEDD_IRQ_STAT:   s_axi_rdata <= {26'h0, stat_q};
               `IEDD_IRQ_MASK:   s_axi_rdata <= {26'h0, mask_q};
               default:          s_axi_rdata <= 32'h0000_0000;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // iedd_top

// >>> test/iedd_monitor.sv
// Assertion checker for the input event block
`timescale 1ns/10ps
module iedd_monitor (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Read handshake
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   // Events and level
   input wire on_rising_edge,
   input wire on_falling_edge,
   input wire on_activation_reached,
   input wire on_hold_passed,
   input wire on_hold_failed,
   input wire query_high,
   input wire query_low
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Remembers an activation so pass and fail can be traced back to it
   logic act_seen_q;
   always @(posedge aclk) begin
      if (!aresetn) begin
         act_seen_q <= 1'b0;
      end else if (on_activation_reached) begin
         act_seen_q <= 1'b1;
      end else if (on_hold_passed || on_hold_failed) begin
         act_seen_q <= 1'b0;
      end
   end
   sequence s_ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_query_pair: assert property (query_high != query_low)
      else $error("high and low queries agree");
   a_edge_excl: assert property (!(on_rising_edge && on_falling_edge))
      else $error("rise and fall in one cycle");
   a_rise_pulse: assert property (on_rising_edge |=> !on_rising_edge)
      else $error("rise event longer than one cycle");
   a_rise_level: assert property (on_rising_edge |-> ##[0:2] query_high)
      else $error("rise event without high level");
   a_fall_level: assert property (on_falling_edge |-> ##[0:2] query_low)
      else $error("fall event without low level");
   a_fail_after_act: assert property (on_hold_failed |-> act_seen_q)
      else $error("fail without prior activation");
   a_pass_after_act: assert property (on_hold_passed |-> act_seen_q)
      else $error("pass without prior activation");
   a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
      else $error("read data late");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
endmodule // iedd_monitor
bind iedd_top iedd_monitor u_mon (
   .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .on_rising_edge(on_rising_edge), .on_falling_edge(on_falling_edge),
   .on_activation_reached(on_activation_reached), .on_hold_passed(on_hold_passed),
   .on_hold_failed(on_hold_failed), .query_high(query_high), .query_low(query_low)
);

// >>> test/iedd_pin_model.sv
// Pin source that holds the input high for a commanded count of cycles
`timescale 1ns/10ps
module iedd_pin_model (
   // Clock
   input  wire        aclk,
   // Pulse request
   input  wire        go,
   input  wire [31:0] width,
   // Pin
   output wire        raw_in
);
   // Cycles left high; the pin idles low between pulses
   logic [31:0] left_q = 32'h0;
   always @(posedge aclk) begin
      if (go) begin
         left_q <= width;
      end else if (left_q != 32'h0) begin
         left_q <= left_q - 32'h1;
      end
   end
   assign raw_in = (left_q != 32'h0);
endmodule // iedd_pin_model

// >>> test/iedd_top_test.sv
// Self-checking bench for the input event block
`timescale 1ns/10ps
`include "iedd_map.vh"
module iedd_top_test;
   // Bench-driven inputs
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        go = 1'b0;
   logic [31:0] width = 32'h0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   // Design answers
   wire         raw_in, awready, wready, bvalid, arready, rvalid, qh, ql, irq;
   wire [1:0]   bresp, rresp;
   wire [31:0]  rdata;
   wire [4:0]   ev;
   // Bookkeeping
   logic [4:0]  seen = 5'h0;
   logic        clr = 1'b0;
   logic [31:0] rd_val, hi_cnt = 32'h0;
   logic [1:0]  rd_resp;
   int          cyc = 0;
   int          num_errors = 0;
   int          num_checks = 0;

   iedd_top dut (
      .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .raw_in(raw_in),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .on_rising_edge(ev[0]), .on_falling_edge(ev[1]), .on_activation_reached(ev[2]),
      .on_hold_passed(ev[3]), .on_hold_failed(ev[4]), .query_high(qh), .query_low(ql),
      .irq(irq)
   );
   iedd_pin_model pin (.aclk(aclk), .go(go), .width(width), .raw_in(raw_in));

   // 100 ns clock
   initial begin
      forever #50 aclk = ~aclk;
   end
   // Gathers event pulses and high cycles; the ceiling cuts a hang short
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      seen <= clr ? 5'h0 : (seen | ev);
      hi_cnt <= clr ? 32'h0 : hi_cnt + {31'h0, qh === 1'b1};
      if (cyc == 50000) begin
         num_errors++;
         conclude();
      end
   end
   task check(input string n, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, exp, got);
      end
   endtask
   task conclude;
      $display("Checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Bus write: each channel released at its own handshake
   task wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      check("bresp", bresp, 32'h0);
      // One idle edge so a following transfer never reassigns a strobe in one step
      @(posedge aclk);
   endtask
   task rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      rd_val = rdata;
      rd_resp = rresp;
      @(posedge aclk);
   endtask
   task wrc(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
      wr(a, d);
      rd(a);
      check($sformatf("reg %h", a), rd_val, e);
   endtask
   task start_count;
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
   endtask
   task pulse(input logic [31:0] n);
      width <= n;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
   endtask
   // Overrides take effect only while their gate is open
   task t_regs;
      wrc(`IEDD_ACT_DELAY, 32'h5, 32'h64);
      wrc(`IEDD_HOLD_DUR, 32'h7, 32'h1f4);
      wrc(`IEDD_RATE_LIM, 32'h3, 32'ha);
      wr(`IEDD_CTRL, 32'he);
      wrc(`IEDD_RATE_LIM, 32'h3, 32'h3);
      wrc(`IEDD_ACT_DELAY, 32'h1, 32'h1);
      wrc(`IEDD_HOLD_DUR, 32'h1, 32'h1);
      wr(`IEDD_PROC_MODE, 32'h2);
      wrc(`IEDD_SMOOTH, 32'h6, 32'h6);
      wrc(`IEDD_UPPER_CUT, 32'h3, 32'h3);
      wrc(`IEDD_FRONT_GAIN, 32'h7, 32'h7);
      wr(`IEDD_PROC_MODE, 32'h1);
      wrc(`IEDD_SMOOTH, 32'h0, 32'h6);
      wrc(`IEDD_UPPER_CUT, 32'h5, 32'h3);
      wrc(`IEDD_FRONT_GAIN, 32'h8, 32'h8);
      wr(`IEDD_PROC_MODE, 32'h0);
      wrc(`IEDD_FRONT_GAIN, 32'h9, 32'h8);
      wr(`IEDD_PROC_MODE, 32'h2);
      wr(`IEDD_CTRL, 32'h2);
      wrc(`IEDD_LOWER_CUT, 32'h5, 32'h0);
      rd(8'h40);
      check("unmapped rresp", rd_resp, 32'h2);
   endtask
   // Short pin pulse: edges, queries, flag word and interrupt
   task t_edges;
      start_count;
      pulse(32'h28);
      repeat (10) @(posedge aclk);
      check("high", qh, 32'h1);
      rd(`IEDD_FLAGS);
      check("flags", rd_val, 32'h1);
      repeat (40) @(posedge aclk);
      check("events", seen, 32'h3);
      check("low", ql, 32'h1);
      rd(`IEDD_IRQ_STAT);
      check("stat", rd_val, 32'h6);
      wr(`IEDD_IRQ_MASK, 32'h2);
      check("irq on", irq, 32'h1);
      wr(`IEDD_IRQ_STAT, 32'h2);
      check("irq off", irq, 32'h0);
      wrc(`IEDD_IRQ_STAT, 32'h4, 32'h0);
   endtask
   // Forcing commands; the blip must last one cycle
   task t_force;
      wr(`IEDD_CMD, 32'h1);
      repeat (4) @(posedge aclk);
      check("forced high", qh, 32'h1);
      wr(`IEDD_CMD, 32'h2);
      repeat (4) @(posedge aclk);
      check("forced low", ql, 32'h1);
      start_count;
      wr(`IEDD_CMD, 32'h4);
      repeat (6) @(posedge aclk);
      check("blip cycles", hi_cnt, 32'h1);
      check("blip events", seen, 32'h3);
      wr(`IEDD_CMD, 32'h8);
   endtask
   // Silenced input still shows its level but raises nothing
   task t_silence;
      wr(`IEDD_CTRL, 32'h3);
      // Forcing left rise and fall status bits set; clear them first
      wr(`IEDD_IRQ_STAT, 32'h3e);
      start_count;
      pulse(32'h14);
      repeat (30) @(posedge aclk);
      check("muted events", seen, 32'h0);
      check("muted level", hi_cnt, 32'h14);
      rd(`IEDD_IRQ_STAT);
      check("muted stat", rd_val, 32'h0);
      wr(`IEDD_CTRL, 32'h2);
   endtask
   // Activation 1 ms: 25000 cycles held passes, 15000 with 2 ms hold fails
   task t_dur;
      start_count;
      pulse(32'h61a8);
      repeat (25100) @(posedge aclk);
      check("pass run", seen, 32'hf);
      wrc(`IEDD_HOLD_DUR, 32'h2, 32'h2);
      start_count;
      pulse(32'h3a98);
      repeat (15100) @(posedge aclk);
      check("fail run", seen, 32'h17);
   endtask
   // Main sequence
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs;
      t_edges;
      t_force;
      t_silence;
      t_dur;
      conclude();
   end
endmodule // iedd_top_test
